//--- common/dmc_defines.vh
`ifndef DMC_DEFINES_VH
`define DMC_DEFINES_VH

// Bank-address selector of a register load (BA1:BA0)
`define DMC_SEL_BASE        2'h0
`define DMC_SEL_EXT         2'h1

// Command encoding {cs_n, ras_n, cas_n, we_n}
`define DMC_CMD_LOAD        4'h0
`define DMC_CMD_REFRESH     4'h1
`define DMC_CMD_READ        4'h5
`define DMC_CMD_WRITE       4'h4

// Base configuration register fields
`define DMC_BASE_LAT_LO     4
`define DMC_BASE_LAT_HI     6
`define DMC_BASE_LOOP_RST   8
`define DMC_BASE_REC_LO     9
`define DMC_BASE_REC_HI     11
`define DMC_BASE_EXIT_SPD   12

// Extended configuration register fields
`define DMC_EXT_LOOP_EN     0
`define DMC_EXT_DRV_RED     1
`define DMC_EXT_TERM_LO     2
`define DMC_EXT_POST_LO     3
`define DMC_EXT_POST_HI     5
`define DMC_EXT_TERM_HI     6
`define DMC_EXT_STB_CDIS    10
`define DMC_EXT_RSTB_EN     11
`define DMC_EXT_OUT_OFF     12

// Reset values (17-bit registers)
`define DMC_BASE_RST        17'h00632
`define DMC_EXT_RST         17'h00000

// Timing counts in clocks
`define DMC_LOOP_LOCK_CYC   200
`define DMC_TERM_HOLD_CYC   8
`define DMC_FAST_EXIT_CYC   4'h2
`define DMC_SLOW_EXIT_CYC   4'h7

`endif

//--- verilog/dmc_delay_line.v
`timescale 1ns/100ps
// Variable-depth shift line: a pulse entering emerges after sel clocks
module dmc_delay_line #(
   parameter DEPTH = 16,
   parameter SELW  = 4
) (
   input  wire            clk_sys,
   input  wire            arst_n,
   input  wire            din,
   input  wire [SELW-1:0] sel,
   output wire            dout
);
   reg [DEPTH-1:0] line_q;
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         line_q <= {DEPTH{1'b0}};
      end else begin
         line_q <= {line_q[DEPTH-2:0], din};
      end
   end
   // A select of zero passes the input straight through
   assign dout = (sel == {SELW{1'b0}}) ? din : line_q[sel - 1'b1];
endmodule // dmc_delay_line

//--- verilog/dmc_cycle_timer.v
`timescale 1ns/100ps
// Down counter: load starts a wait, busy stays high until it expires
module dmc_cycle_timer #(
   parameter W = 8
) (
   input  wire         clk_sys,
   input  wire         arst_n,
   input  wire         load,
   input  wire [W-1:0] count,
   output wire         busy
);
   reg [W-1:0] cnt_q;
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= {W{1'b0}};
      end else if (load) begin
         cnt_q <= count;
      end else if (cnt_q != {W{1'b0}}) begin
         cnt_q <= cnt_q - 1'b1;
      end
   end
   assign busy = (cnt_q != {W{1'b0}});
endmodule // dmc_cycle_timer

//--- verilog/dmc_mode_config.v
`timescale 1ns/100ps
`include "dmc_defines.vh"
module dmc_mode_config #(
   parameter LOOP_LOCK_CYC = `DMC_LOOP_LOCK_CYC,
   parameter TERM_HOLD_CYC = `DMC_TERM_HOLD_CYC,
   parameter X8_CONFIG     = 1
) (
   input  wire        clk_sys,
   input  wire        arst_n,
   input  wire        cke,
   input  wire [3:0]  cmd,
   input  wire [1:0]  bank_sel,
   input  wire [14:0] addr,
   input  wire        auto_pre,
   input  wire        write_last_data,
   input  wire        banks_idle,
   input  wire        termination_control,
   input  wire        strobe_drive,
   output reg         read_issue_q,
   output reg         read_data_start_q,
   output reg         write_data_start_q,
   output reg         precharge_start_q,
   output reg         loop_enabled_q,
   output reg         loop_locked_q,
   output reg         loop_frozen_q,
   output reg         self_refresh_q,
   output reg         active_pd_q,
   output reg         precharge_pd_q,
   output reg  [3:0]  exit_delay_q,
   output reg         drive_reduce_q,
   output reg         strobe_oe_q,
   output reg         strobe_comp_oe_q,
   output reg         read_only_strobe_oe_q,
   output reg         read_only_strobe_comp_oe_q,
   output reg         data_oe_q,
   output reg  [1:0]  termination_value_q,
   output reg         termination_on_q,
   output reg  [3:0]  read_delay_total_q,
   output reg  [3:0]  write_delay_total_q
);
   reg  [16:0] base_config_reg_q;
   reg  [16:0] extended_config_reg_q;
   reg         pend_pre_q;
   reg  [3:0]  rec_cnt_q;
   reg         loop_rst_req_q;
   reg         term_hold_load;
   reg         lock_load;

   wire [2:0]  latency_field      = base_config_reg_q[`DMC_BASE_LAT_HI:`DMC_BASE_LAT_LO];
   wire [2:0]  recovery_field     = base_config_reg_q[`DMC_BASE_REC_HI:`DMC_BASE_REC_LO];
   wire        exit_speed_bit     = base_config_reg_q[`DMC_BASE_EXIT_SPD];
   wire [2:0]  posted_delay_field = extended_config_reg_q[`DMC_EXT_POST_HI:`DMC_EXT_POST_LO];
   wire        loop_enable_bit    = extended_config_reg_q[`DMC_EXT_LOOP_EN];
   wire        drive_reduce_bit   = extended_config_reg_q[`DMC_EXT_DRV_RED];
   wire        termination_select_low  = extended_config_reg_q[`DMC_EXT_TERM_LO];
   wire        termination_select_high = extended_config_reg_q[`DMC_EXT_TERM_HI];
   wire        strobe_comp_disable_bit = extended_config_reg_q[`DMC_EXT_STB_CDIS];
   wire        read_only_strobe_en     = extended_config_reg_q[`DMC_EXT_RSTB_EN];
   wire        output_off_bit          = extended_config_reg_q[`DMC_EXT_OUT_OFF];

   // Whole-clock latency only; the field is binary, no half-clock codes
   function [3:0] lat_clocks;
      input [2:0] f;
      begin
         lat_clocks = {1'b0, f};
      end
   endfunction

   // Recovery code 1..7 means 2..8 clocks
   function [3:0] rec_clocks;
      input [2:0] f;
      begin
         rec_clocks = {1'b0, f} + 4'h1;
      end
   endfunction

   wire cmd_load  = cke && (cmd == `DMC_CMD_LOAD);
   wire cmd_read  = cke && (cmd == `DMC_CMD_READ);
   wire cmd_write = cke && (cmd == `DMC_CMD_WRITE);
   wire load_base = cmd_load && (bank_sel == `DMC_SEL_BASE);
   wire load_ext  = cmd_load && (bank_sel == `DMC_SEL_EXT);
   wire [16:0] load_word = {bank_sel, addr};
   wire [3:0]  rd_total  = {1'b0, posted_delay_field} + lat_clocks(latency_field);

   // Self refresh is a refresh issued while cke falls; power-down when idle/active
   reg  cke_q;
   wire sref_entry = cke_q && !cke && (cmd == `DMC_CMD_REFRESH);
   wire sref_exit  = self_refresh_q && cke;
   wire pd_entry   = cke_q && !cke && (cmd != `DMC_CMD_REFRESH) && !self_refresh_q;
   wire pd_exit    = (active_pd_q || precharge_pd_q) && cke;

   // Register loads, loop reset self-clear
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         base_config_reg_q     <= `DMC_BASE_RST;
         extended_config_reg_q <= `DMC_EXT_RST;
         loop_rst_req_q        <= 1'b0;
      end else begin
         if (load_base) begin
            base_config_reg_q <= load_word;
         end else if (loop_rst_req_q) begin
            base_config_reg_q[`DMC_BASE_LOOP_RST] <= 1'b0;
         end
         if (load_ext) begin
            extended_config_reg_q <= load_word;
         end
         loop_rst_req_q <= load_base && load_word[`DMC_BASE_LOOP_RST];
      end
   end

   // Posted delay then latency for reads and writes
   wire rd_internal;
   wire rd_data;
   wire wr_data;
   dmc_delay_line #(.DEPTH(8), .SELW(3)) u_post (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .din     (cmd_read),
      .sel     (posted_delay_field),
      .dout    (rd_internal)
   );
   dmc_delay_line #(.DEPTH(16), .SELW(4)) u_rd (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .din     (cmd_read),
      .sel     (rd_total - 4'h1),
      .dout    (rd_data)
   );
   dmc_delay_line #(.DEPTH(16), .SELW(4)) u_wr (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .din     (cmd_write),
      .sel     (rd_total - 4'h2),
      .dout    (wr_data)
   );

   // Loop lock and termination hold timers
   wire lock_busy;
   wire term_busy;
   dmc_cycle_timer #(.W(8)) u_lock (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .load    (lock_load),
      .count   (LOOP_LOCK_CYC[7:0]),
      .busy    (lock_busy)
   );
   dmc_cycle_timer #(.W(8)) u_term (
      .clk_sys (clk_sys),
      .arst_n  (arst_n),
      .load    (term_hold_load),
      .count   (TERM_HOLD_CYC[7:0]),
      .busy    (term_busy)
   );

   always @* begin
      lock_load      = loop_rst_req_q || sref_exit;
      term_hold_load = load_ext && (load_word[`DMC_EXT_TERM_LO] || load_word[`DMC_EXT_TERM_HI]);
   end

   // Write with auto precharge: wait recovery clocks after the last data
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         pend_pre_q        <= 1'b0;
         rec_cnt_q         <= 4'h0;
         precharge_start_q <= 1'b0;
      end else begin
         precharge_start_q <= 1'b0;
         if (write_last_data && auto_pre) begin
            pend_pre_q <= 1'b1;
            // Pulse flop adds one clock, so the count starts two short
            rec_cnt_q  <= rec_clocks(recovery_field) - 4'h2;
         end else if (pend_pre_q) begin
            if (rec_cnt_q == 4'h0) begin
               pend_pre_q        <= 1'b0;
               precharge_start_q <= 1'b1;
            end else begin
               rec_cnt_q <= rec_cnt_q - 4'h1;
            end
         end
      end
   end

   // Power states and loop state
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cke_q          <= 1'b0;
         self_refresh_q <= 1'b0;
         active_pd_q    <= 1'b0;
         precharge_pd_q <= 1'b0;
         exit_delay_q   <= 4'h0;
         loop_enabled_q <= 1'b0;
         loop_locked_q  <= 1'b0;
         loop_frozen_q  <= 1'b0;
      end else begin
         cke_q <= cke;
         if (sref_entry) begin
            self_refresh_q <= 1'b1;
         end else if (sref_exit) begin
            self_refresh_q <= 1'b0;
         end
         if (pd_entry) begin
            active_pd_q    <= !banks_idle;
            precharge_pd_q <= banks_idle;
         end else if (pd_exit) begin
            active_pd_q    <= 1'b0;
            precharge_pd_q <= 1'b0;
         end
         if (pd_entry && !banks_idle) begin
            exit_delay_q <= exit_speed_bit ? `DMC_SLOW_EXIT_CYC : `DMC_FAST_EXIT_CYC;
         end else if (pd_entry) begin
            exit_delay_q <= `DMC_FAST_EXIT_CYC;
         end
         loop_frozen_q  <= active_pd_q && exit_speed_bit && !pd_exit;
         loop_enabled_q <= loop_enable_bit && !self_refresh_q && !sref_entry;
         loop_locked_q  <= loop_enable_bit && !self_refresh_q && !lock_busy && !lock_load;
      end
   end

   // Output buffers, strobes and termination
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         read_issue_q               <= 1'b0;
         read_data_start_q          <= 1'b0;
         write_data_start_q         <= 1'b0;
         drive_reduce_q             <= 1'b0;
         strobe_oe_q                <= 1'b0;
         strobe_comp_oe_q           <= 1'b0;
         read_only_strobe_oe_q      <= 1'b0;
         read_only_strobe_comp_oe_q <= 1'b0;
         data_oe_q                  <= 1'b0;
         termination_value_q        <= 2'h0;
         termination_on_q           <= 1'b0;
         read_delay_total_q         <= 4'h0;
         write_delay_total_q        <= 4'h0;
      end else begin
         read_issue_q        <= rd_internal;
         read_data_start_q   <= rd_data;
         write_data_start_q  <= wr_data;
         read_delay_total_q  <= rd_total;
         write_delay_total_q <= rd_total - 4'h1;
         drive_reduce_q      <= drive_reduce_bit;
         data_oe_q           <= strobe_drive && !output_off_bit;
         strobe_oe_q         <= strobe_drive && !output_off_bit;
         strobe_comp_oe_q    <= strobe_drive && !output_off_bit && !strobe_comp_disable_bit;
         // Extra strobe (x8 only) follows strobe drive, but is off while outputs are off and in the clock after a write command; during writes it is ignored
         read_only_strobe_oe_q <= (X8_CONFIG != 0) && read_only_strobe_en && strobe_drive
                                  && !cmd_write && !output_off_bit;
         read_only_strobe_comp_oe_q <= (X8_CONFIG != 0) && read_only_strobe_en && strobe_drive
                                  && !cmd_write && !output_off_bit
                                  && !strobe_comp_disable_bit;
         termination_value_q <= {termination_select_high, termination_select_low};
         termination_on_q    <= termination_control && !self_refresh_q && !term_busy
                                && (termination_select_high || termination_select_low);
      end
   end
endmodule // dmc_mode_config

//--- dv/dmc_mode_config_asserts.sv
`timescale 1ns/100ps
`include "dmc_defines.vh"
module dmc_mode_config_asserts (
   input wire        clk_sys,
   input wire        arst_n,
   input wire        cke,
   input wire [3:0]  cmd,
   input wire [1:0]  bank_sel,
   input wire [14:0] addr,
   input wire        auto_pre,
   input wire        write_last_data,
   input wire        read_issue_q,
   input wire        read_data_start_q,
   input wire        write_data_start_q,
   input wire        precharge_start_q,
   input wire        loop_frozen_q,
   input wire        active_pd_q,
   input wire [3:0]  exit_delay_q,
   input wire        drive_reduce_q,
   input wire        data_oe_q,
   input wire [1:0]  termination_value_q,
   input wire [3:0]  read_delay_total_q,
   input wire [3:0]  write_delay_total_q
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   wire         ld = cke && cmd == `DMC_CMD_LOAD;
   wire         rd = cke && cmd == `DMC_CMD_READ;
   wire         wr = cke && cmd == `DMC_CMD_WRITE;
   reg  [2:0]   lat_q, post_q, rec_q;
   reg          slow_q;
   reg  [12:0]  ext_q;
   reg  [1:0]   age_q;
   reg  [15:0]  ri_q, rd_q, wr_q, pc_q;
   wire [3:0]   tot = lat_q + post_q;
   // Expected pulses ride shift lines: bit k falls due k clocks later
   always @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         {slow_q, rec_q, lat_q} <= 7'h1B;
         {ext_q, post_q, age_q} <= 18'h0;
         {ri_q, rd_q, wr_q, pc_q} <= 64'h0;
      end else begin
         if (ld && bank_sel == `DMC_SEL_BASE)
            {slow_q, rec_q, lat_q} <= {addr[12:9], addr[6:4]};
         if (ld && bank_sel == `DMC_SEL_EXT)
            {ext_q, post_q} <= {addr[12:0], addr[5:3]};
         age_q <= ld ? 2'h0 : age_q + {1'b0, age_q != 2'h3};
         ri_q <= (ri_q >> 1) | (16'(rd) << post_q);
         rd_q <= (rd_q >> 1) | (16'(rd) << (tot - 4'h1));
         wr_q <= (wr_q >> 1) | (16'(wr) << (tot - 4'h2));
         pc_q <= (pc_q >> 1) | (16'(write_last_data && auto_pre) << rec_q);
      end
   end
   sequence apd_entry;
      $rose(active_pd_q) ##1 active_pd_q;
   endsequence
   AST_RD_ISSUE: assert property (read_issue_q == ri_q[0])
      else $error("internal read off its posted delay");
   AST_RD_DATA: assert property (read_data_start_q == rd_q[0])
      else $error("read data start off its latency");
   AST_WR_DATA: assert property (write_data_start_q == wr_q[0])
      else $error("write data start off its latency");
   AST_PRECHG: assert property (precharge_start_q == pc_q[0])
      else $error("auto precharge off its recovery count");
   AST_TOTALS: assert property (age_q == 2'h3 |->
      read_delay_total_q == tot && write_delay_total_q == tot - 4'h1)
      else $error("latency totals disagree with loaded fields");
   AST_DRIVE: assert property (age_q == 2'h3 |->
      drive_reduce_q == ext_q[1] && termination_value_q == {ext_q[6], ext_q[2]})
      else $error("drive or termination select wrong");
   AST_OUT_OFF: assert property (age_q == 2'h3 && ext_q[12] |-> !data_oe_q)
      else $error("data output enabled while outputs off");
   AST_EXIT: assert property (apd_entry |->
      exit_delay_q == (slow_q ? 4'h7 : 4'h2) && loop_frozen_q == slow_q)
      else $error("power-down exit speed wrong");
endmodule // dmc_mode_config_asserts

bind dmc_mode_config dmc_mode_config_asserts u_chk (
   .clk_sys, .arst_n, .cke, .cmd, .bank_sel, .addr, .auto_pre, .write_last_data,
   .read_issue_q, .read_data_start_q, .write_data_start_q, .precharge_start_q,
   .loop_frozen_q, .active_pd_q, .exit_delay_q, .drive_reduce_q, .data_oe_q,
   .termination_value_q, .read_delay_total_q, .write_delay_total_q);

//--- dv/dmc_ctl_model.sv
`timescale 1ns/100ps
`include "dmc_defines.vh"
// Controller side of the command bus; all lines change just after a rising edge
// Clock stays above 25 MHz, so no precharge-all follows a refresh
module dmc_ctl_model (
   input  wire         clk_sys,
   output logic        cke,
   output logic [3:0]  cmd,
   output logic [1:0]  bank_sel,
   output logic [14:0] addr
);
   integer cyc = 0;
   always @(posedge clk_sys) cyc <= cyc + 1;
   initial begin
      cke = 1'b1;
      cmd = 4'hF;
      {bank_sel, addr} = 17'h0;
   end
   task automatic issue(input logic k, input logic [3:0] c, input logic [1:0] b,
                        input logic [14:0] a, output integer at);
      @(posedge clk_sys);
      at = cyc;
      cke <= k;
      cmd <= c;
      {bank_sel, addr} <= {b, a};
   endtask
   // Deselect; address is inverted so a stale value never looks held
   task automatic idle();
      @(posedge clk_sys);
      cmd <= 4'hF;
      {bank_sel, addr} <= ~{bank_sel, addr};
   endtask
   task automatic load(input logic [1:0] b, input logic [14:0] a);
      integer at;
      issue(1'b1, `DMC_CMD_LOAD, b, a, at);
      idle();
      repeat (4) @(posedge clk_sys);
   endtask
endmodule // dmc_ctl_model

//--- dv/test_ddr2_mode_register_config.sv
`timescale 1ns/100ps
`include "dmc_defines.vh"
module test_ddr2_mode_register_config;
   localparam LOCK = 20;
   logic        clk_sys = 1'b0, arst_n = 1'b0, auto_pre = 1'b0, write_last_data = 1'b0;
   logic        banks_idle = 1'b0, termination_control = 1'b0, strobe_drive = 1'b1;
   wire         cke, read_issue_q, read_data_start_q, write_data_start_q, precharge_start_q;
   wire         loop_enabled_q, loop_locked_q, loop_frozen_q, self_refresh_q, active_pd_q;
   wire         precharge_pd_q, drive_reduce_q, termination_on_q, data_oe_q;
   wire         strobe_comp_oe_q, read_only_strobe_oe_q;
   wire  [3:0]  cmd, exit_delay_q, read_delay_total_q, write_delay_total_q;
   wire  [1:0]  bank_sel, termination_value_q;
   wire  [14:0] addr;
   integer      fail_count = 0, num_checks = 0, seed = 71534;
   integer      q_ri[$], q_rd[$], q_wr[$], q_pc[$];
   integer      i, j, at, lat, post, rec, slow, e;

   always #10 clk_sys = ~clk_sys;

   dmc_ctl_model u_dmc_ctl_model (.clk_sys, .cke, .cmd, .bank_sel, .addr);
   dmc_mode_config #(.LOOP_LOCK_CYC(LOCK)) u_dmc_mode_config (
      .clk_sys, .arst_n, .cke, .cmd, .bank_sel, .addr, .auto_pre, .write_last_data,
      .banks_idle, .termination_control, .strobe_drive, .read_issue_q, .read_data_start_q,
      .write_data_start_q, .precharge_start_q, .loop_enabled_q, .loop_locked_q,
      .loop_frozen_q, .self_refresh_q, .active_pd_q, .precharge_pd_q, .exit_delay_q,
      .drive_reduce_q, .strobe_oe_q(), .strobe_comp_oe_q, .read_only_strobe_oe_q,
      .read_only_strobe_comp_oe_q(), .data_oe_q, .termination_value_q, .termination_on_q,
      .read_delay_total_q, .write_delay_total_q);

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // A pulse with nothing queued, or at the wrong cycle, is a mismatch
   task automatic pulse(input logic p, ref integer q[$]);
      if (p !== 1'b0)
         check(16'(u_dmc_ctl_model.cyc), q.size() ? 16'(q.pop_front()) : 16'hFFFF);
   endtask
   task automatic end_sim();
      $display("checks %0d errors %0d", num_checks, fail_count);
      if (fail_count == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   always @(negedge clk_sys) begin
      if (arst_n) begin
         pulse(read_issue_q, q_ri);
         pulse(read_data_start_q, q_rd);
         pulse(write_data_start_q, q_wr);
         pulse(precharge_start_q, q_pc);
      end
   end

   initial begin
      repeat (30000) @(posedge clk_sys);
      fail_count++;
      end_sim();
   end

   initial begin
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk_sys);
      check(read_delay_total_q, 16'h3);
      for (i = 0; i < 12; i++) begin
         lat  = 3 + i % 5;
         post = (i < 5) ? 0 : {$random(seed)} % 7;
         rec  = 1 + i % 7;
         slow = i % 2;
         e    = ($random(seed) & 32'h1C46) | (post << 3) | 1;
         if ((e & 32'h44) == 32'h44) e = e & ~32'h40;
         termination_control <= 1'b0;
         u_dmc_ctl_model.load(`DMC_SEL_EXT, 15'(e));
         u_dmc_ctl_model.load(`DMC_SEL_BASE,
                              15'(slow << 12 | rec << 9 | (i == 0) << 8 | lat << 4 | 2));
         if (i == 0) begin
            check(loop_locked_q, 16'h0);
            repeat (LOCK) @(posedge clk_sys);
            check(loop_locked_q, 16'h1);
         end
         termination_control <= 1'b1;
         auto_pre <= $random(seed);
         for (j = 0; j < 2; j++) begin
            u_dmc_ctl_model.issue(1'b1, `DMC_CMD_READ, 2'(j), 15'h8, at);
            q_ri.push_back(at + post + 2);
            q_rd.push_back(at + lat + post + 1);
         end
         u_dmc_ctl_model.issue(1'b1, `DMC_CMD_WRITE, 2'h2, 15'h10, at);
         q_wr.push_back(at + lat + post);
         u_dmc_ctl_model.idle();
         write_last_data <= 1'b1;
         if (auto_pre)
            q_pc.push_back(u_dmc_ctl_model.cyc + rec + 2);
         @(posedge clk_sys);
         write_last_data <= 1'b0;
         repeat (20) @(posedge clk_sys);
         check(write_delay_total_q, 16'(lat + post - 1));
         check(drive_reduce_q, 16'(e >> 1 & 1));
         check(termination_value_q, 16'(e >> 5 & 2 | e >> 2 & 1));
         check(termination_on_q, 16'((e & 32'h44) != 0));
         check(data_oe_q, 16'(e >> 12 & 1 ^ 1));
         check(strobe_comp_oe_q, 16'((e & 32'h1400) == 0));
         check(read_only_strobe_oe_q, 16'((e & 32'h1800) == 32'h800));
         banks_idle <= i[1];
         u_dmc_ctl_model.issue(1'b0, 4'hF, 2'h0, 15'h0, at);
         repeat (3) @(posedge clk_sys);
         check(active_pd_q, 16'(!banks_idle));
         check(precharge_pd_q, 16'(banks_idle));
         check(loop_frozen_q, 16'(slow & !banks_idle));
         if (!banks_idle)
            check(exit_delay_q, slow ? 16'h7 : 16'h2);
         u_dmc_ctl_model.issue(1'b1, 4'hF, 2'h0, 15'h0, at);
         repeat (8) @(posedge clk_sys);
      end
      termination_control <= 1'b0;
      banks_idle <= 1'b1;
      u_dmc_ctl_model.issue(1'b0, `DMC_CMD_REFRESH, 2'h0, 15'h0, at);
      u_dmc_ctl_model.idle();
      repeat (3) @(posedge clk_sys);
      check(self_refresh_q, 16'h1);
      check(loop_enabled_q, 16'h0);
      u_dmc_ctl_model.issue(1'b1, 4'hF, 2'h0, 15'h0, at);
      repeat (8) @(posedge clk_sys);
      check(loop_enabled_q, 16'h1);
      check(16'(q_rd.size() + q_ri.size() + q_wr.size() + q_pc.size()), 16'h0);
      end_sim();
   end
endmodule // test_ddr2_mode_register_config
